// ==== src/burst_sram_pkg.sv ====
// shared constants and carrier types for the pipelined burst sram core
// assumes a single synchronous bus clock shared with the bus master
`default_nettype none
package burst_sram_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int WORDS = 524288;
  localparam int BURST_W = 2;
  localparam logic [LANES-1:0] ALL_LANES = 4'hF;
  localparam logic [LANES-1:0] NO_LANES = 4'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [BURST_W-1:0] BURST_START = 2'h0;

  // bus pins as captured by the input registers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic primary_select_n;
    logic expand_select_b;
    logic expand_select_c_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic [LANES-1:0] lane_write_en_n;
    logic lane_write_master_n;
    logic all_lanes_write_n;
  } bus_pins_t;

  // idle bus: no strobe, no write, device not selected
  localparam bus_pins_t IDLE_PINS = '{
    addr: 19'h00000,
    data: 36'h000000000,
    primary_select_n: 1'b1,
    expand_select_b: 1'b0,
    expand_select_c_n: 1'b1,
    proc_addr_strobe_n: 1'b1,
    ctrl_addr_strobe_n: 1'b1,
    burst_advance_n: 1'b1,
    lane_write_en_n: 4'hF,
    lane_write_master_n: 1'b1,
    all_lanes_write_n: 1'b1
  };
endpackage : burst_sram_pkg
`default_nettype wire

// ==== src/pipelined_burst_sram_core.sv ====
// pipelined burst sram core, 512K x 36, single clocked bus
// assumes bus master drives all synchronous pins from sys_clk;
// output enable and sleep arrive asynchronously, burst order is a strap
`default_nettype none
module pipelined_burst_sram_core
  import burst_sram_pkg::*;
#(
  parameter bit SINGLE_ENABLE = 1'b0
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic primary_select_n,
  input wire logic expand_select_b,
  input wire logic expand_select_c_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic [LANES-1:0] lane_write_en_n,
  input wire logic lane_write_master_n,
  input wire logic all_lanes_write_n,
  input wire logic out_enable_n,
  input wire logic sleep_req,
  input wire logic burst_linear
);

  bus_pins_t pins;
  bus_pins_t in_d;
  bus_pins_t in_q;
  logic [DATA_W-1:0] mem [WORDS];
  logic [ADDR_W-1:0] base_d;
  logic [ADDR_W-1:0] base_q;
  logic [BURST_W-1:0] cnt_d;
  logic [BURST_W-1:0] cnt_q;
  logic sel_d;
  logic sel_q;
  logic [DATA_W-1:0] data_d;
  logic [DATA_W-1:0] data_q;
  logic valid_d;
  logic valid_q;
  logic ce_ok;
  logic proc_load;
  logic load;
  logic wr_req;
  logic do_wr;
  logic do_rd;
  logic [LANES-1:0] lane_mask;
  logic [BURST_W-1:0] offs;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] old_word;
  logic [DATA_W-1:0] merged;

  assign pins = '{
    addr: addr,
    data: dq_in,
    primary_select_n: primary_select_n,
    expand_select_b: expand_select_b,
    expand_select_c_n: expand_select_c_n,
    proc_addr_strobe_n: proc_addr_strobe_n,
    ctrl_addr_strobe_n: ctrl_addr_strobe_n,
    burst_advance_n: burst_advance_n,
    lane_write_en_n: lane_write_en_n,
    lane_write_master_n: lane_write_master_n,
    all_lanes_write_n: all_lanes_write_n
  };

  // input register stage; reset parks it on an idle bus
  always_comb
  begin
    in_d = rst_n ? pins : IDLE_PINS;
  end

  always_ff @(posedge sys_clk)
  begin
    in_q <= in_d;
  end

  // decode of the registered controls
  always_comb
  begin
    if (SINGLE_ENABLE)
    begin
      ce_ok = ~in_q.primary_select_n;
    end
    else
    begin
      ce_ok = ~in_q.primary_select_n & in_q.expand_select_b &
              ~in_q.expand_select_c_n;
    end
    // processor strobe is ignored while the primary enable is high
    proc_load = ~in_q.proc_addr_strobe_n & ~in_q.primary_select_n;
    load = proc_load | ~in_q.ctrl_addr_strobe_n;
    if (~in_q.all_lanes_write_n)
    begin
      lane_mask = ALL_LANES;
    end
    else if (~in_q.lane_write_master_n)
    begin
      lane_mask = ~in_q.lane_write_en_n;
    end
    else
    begin
      lane_mask = NO_LANES;
    end
    wr_req = lane_mask != NO_LANES;
  end

  // burst address generation
  always_comb
  begin
    base_d = base_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    if (load)
    begin
      base_d = in_q.addr;
      cnt_d = BURST_START;
      sel_d = ce_ok;
    end
    else if (~in_q.burst_advance_n)
    begin
      cnt_d = cnt_q + BURST_STEP;
    end
    // two-bit sum wraps inside the four-word group
    if (burst_linear)
    begin
      offs = base_d[BURST_W-1:0] + cnt_d;
    end
    else
    begin
      offs = base_d[BURST_W-1:0] ^ cnt_d;
    end
    acc_addr = {base_d[ADDR_W-1:BURST_W], offs};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      base_q <= '0;
      cnt_q <= BURST_START;
      sel_q <= 1'b0;
    end
    else
    begin
      base_q <= base_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
    end
  end

  // array access; a selected processor strobe cycle is always a read
  always_comb
  begin
    do_wr = sel_d & wr_req & ~proc_load;
    do_rd = sel_d & ~do_wr;
    old_word = mem[acc_addr];
    for (int i = 0; i < LANES; i++)
    begin
      merged[i*LANE_W +: LANE_W] = lane_mask[i] ?
        in_q.data[i*LANE_W +: LANE_W] : old_word[i*LANE_W +: LANE_W];
    end
    data_d = do_rd ? old_word : data_q;
    valid_d = do_rd;
  end

  // write completes on the next edge with no external pulse shaping
  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
    begin
      mem[acc_addr] <= merged;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      data_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      data_q <= data_d;
      valid_q <= valid_d;
    end
  end

  assign dq_out = data_q;
  // output enable and sleep bypass every register so the drivers
  // turn round at once; the master must keep enable off on writes
  assign dq_oe = valid_q & ~out_enable_n & ~sleep_req;

  in_reg_a: assert property (
    @(posedge sys_clk)
    $past(rst_n) |-> in_q == $past(pins))
    else $error("input register did not capture bus pins");

  addr_load_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    load |=> base_q == $past(in_q.addr) && cnt_q == BURST_START)
    else $error("address not loaded on strobe");

  burst_step_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !load && !in_q.burst_advance_n |=>
      cnt_q == BURST_W'($past(cnt_q) + BURST_STEP))
    else $error("burst counter did not advance");

  addr_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !load && in_q.burst_advance_n |=> $stable(cnt_q) && $stable(base_q))
    else $error("burst address moved without advance");

  burst_order_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (load && in_q.burst_advance_n) ##1 (!load && !in_q.burst_advance_n)
      |-> acc_addr[BURST_W-1:0] == (burst_linear ?
        BURST_W'(base_q[BURST_W-1:0] + BURST_STEP) :
        (base_q[BURST_W-1:0] ^ BURST_STEP)))
    else $error("wrong second burst address");

  write_merge_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    do_wr |=> mem[$past(acc_addr)] == $past(merged))
    else $error("array write lost");

  // checked in the array after the write, not on the merge net
  lane_keep_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    do_wr && !lane_mask[0] |=>
      mem[$past(acc_addr)][LANE_W-1:0] == $past(old_word[LANE_W-1:0]))
    else $error("unselected lane changed");

  all_lanes_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    do_wr && !in_q.all_lanes_write_n |=>
      mem[$past(acc_addr)] == $past(in_q.data))
    else $error("global write missed a lane");

  oe_async_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (out_enable_n || sleep_req) |-> !dq_oe)
    else $error("drivers on while disabled");

  read_pipe_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    do_rd |=> valid_q && dq_out == $past(old_word))
    else $error("read word not registered next cycle");

  deselect_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    load && !ce_ok |=> !dq_oe)
    else $error("bus not released after deselect");

  select_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    load && in_q.primary_select_n |=> !sel_q)
    else $error("selected with primary enable high");

endmodule : pipelined_burst_sram_core
`default_nettype wire

// ==== tb/bus_master.sv ====
// bus master model driving the synchronous pins of the burst sram core
// assumes the bench calls its tasks; pins change on falling edges only
`default_nettype none
module bus_master
  import burst_sram_pkg::*;
(
  input wire logic sys_clk,
  output var bus_pins_t p,
  output var logic out_enable_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    p = IDLE_PINS;
    out_enable_n = 1'b1;
  end
  // released data lines flip so a stale word can never read as valid
  task automatic go(input bus_pins_t v);
    @(negedge sys_clk);
    if (v.all_lanes_write_n && v.lane_write_master_n)
      v.data = ~p.data;
    out_enable_n = ~(v.all_lanes_write_n & v.lane_write_master_n);
    p = v;
  endtask
  // off: 0 selected, 1..3 one enable inactive
  function automatic bus_pins_t sel(input logic [ADDR_W-1:0] a,
    input logic [1:0] off);
    bus_pins_t v;
    v = IDLE_PINS;
    v.addr = a;
    v.primary_select_n = (off == 2'h1);
    v.expand_select_b = (off != 2'h2);
    v.expand_select_c_n = (off == 2'h3);
    return v;
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic g, input logic [LANES-1:0] bw);
    bus_pins_t v;
    v = sel(a, 2'h0);
    v.ctrl_addr_strobe_n = 1'b0;
    v.data = d;
    v.all_lanes_write_n = g;
    v.lane_write_master_n = 1'b0;
    v.lane_write_en_n = bw;
    go(v);
  endtask
  task automatic ld(input logic [ADDR_W-1:0] a, input logic [1:0] off,
    input logic pr);
    bus_pins_t v;
    v = sel(a, off);
    v.proc_addr_strobe_n = ~pr;
    v.ctrl_addr_strobe_n = pr;
    go(v);
  endtask
  task automatic step(input logic adv_n);
    bus_pins_t v;
    v = IDLE_PINS;
    v.burst_advance_n = adv_n;
    go(v);
  endtask
endmodule // bus_master
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the burst sram core with a bus master model
// assumes read data shows two falling edges after the strobe cycle
`default_nettype none
module tb
  import burst_sram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, sleep_req, burst_linear, out_enable_n, dq_oe;
  bus_pins_t p;
  logic [DATA_W-1:0] dq_out;
  logic [DATA_W-1:0] ref_mem [int];
  logic [1:0] cs [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
  logic [31:0] seed;
  int fails, cmp_count;
  bus_master m (.sys_clk(sys_clk), .p(p), .out_enable_n(out_enable_n));
  pipelined_burst_sram_core dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .addr(p.addr), .dq_in(p.data), .dq_out(dq_out), .dq_oe(dq_oe),
    .primary_select_n(p.primary_select_n),
    .expand_select_b(p.expand_select_b),
    .expand_select_c_n(p.expand_select_c_n),
    .proc_addr_strobe_n(p.proc_addr_strobe_n),
    .ctrl_addr_strobe_n(p.ctrl_addr_strobe_n),
    .burst_advance_n(p.burst_advance_n),
    .lane_write_en_n(p.lane_write_en_n),
    .lane_write_master_n(p.lane_write_master_n),
    .all_lanes_write_n(p.all_lanes_write_n),
    .out_enable_n(out_enable_n), .sleep_req(sleep_req),
    .burst_linear(burst_linear));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] offs(input logic [1:0] b, c,
    input logic lin);
    return lin ? b + c : b ^ c;
  endfunction
  task automatic chk(input logic [DATA_W-1:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wrm(input logic [ADDR_W-1:0] a, input logic g,
    input logic [3:0] bw);
    logic [DATA_W-1:0] d, e;
    d = DATA_W'({rnd(), rnd()});
    e = ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : d;
    for (int i = 0; i < LANES; i++)
      if (!g || !bw[i])
        e[i*LANE_W+:LANE_W] = d[i*LANE_W+:LANE_W];
    ref_mem[int'(a)] = e;
    m.wr(a, d, g, bw);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // a run needs some 230 cycles; this limit is far beyond that
  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end
  initial
  begin
    logic [ADDR_W-1:0] base, ea;
    seed = 32'h0F9F25E1;
    rst_n = 1'b0;
    sleep_req = 1'b0;
    burst_linear = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int it = 0; it < 12; it++)
    begin
      base = ADDR_W'(rnd());
      for (int k = 0; k < 4; k++)
        wrm({base[18:2], 2'(k)}, 1'b0, 4'(rnd()));
      for (int k = 0; k < 4; k++)
        wrm(ADDR_W'({base[18:2], 2'(rnd())}), 1'(rnd()), 4'(rnd()));
      burst_linear = it[0];
      m.ld(base, 2'h0, it[1]);
      for (int n = 1; n < 8; n++)
      begin
        m.step(n == 2 || n > 5);
        if (n >= 2)
        begin
          ea = {base[18:2], offs(base[1:0], cs[n-2], burst_linear)};
          chk(dq_out, ref_mem[int'(ea)]);
        end
        if (n == 3)
        begin
          sleep_req = it[0];
          m.out_enable_n = ~it[0];
          #1 chk({35'h0, dq_oe}, 36'h0);
          sleep_req = 1'b0;
          m.out_enable_n = 1'b0;
          #1 chk({35'h0, dq_oe}, 36'h1);
        end
      end
      m.ld(base, 2'(1 + it % 3), 1'b0);
      m.step(1'b1);
      m.step(1'b1);
      chk({35'h0, dq_oe}, 36'h0);
    end
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
